/* shared/adcs_pkg.sv */
// Shared constants and types of the converter sequencer
package adcs_pkg;
  localparam int ADC_BITS = 10;
  localparam int CHAN_COUNT = 8;
  localparam int CONV_TICKS = 12;
  localparam int ABORT_TICKS = 2;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_CTRL0 = 3'h0;
  localparam logic [2:0] OFF_CTRL1 = 3'h1;
  localparam logic [2:0] OFF_RESH = 3'h2;
  localparam logic [2:0] OFF_RESL = 3'h3;
  localparam logic [2:0] OFF_STATUS = 3'h4;
  localparam logic [2:0] OFF_PORT = 3'h5;
  localparam int CS_LO_POS = 6;
  localparam int CHAN_POS = 3;
  localparam int GO_POS = 2;
  localparam int ON_POS = 0;
  localparam int JUST_POS = 7;
  localparam int CS_HI_POS = 6;
  localparam int PCFG_POS = 0;
  localparam int DONE_POS = 0;
  localparam int ACQ_POS = 1;
  localparam int BUSY_POS = 2;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] RES_RST = 8'h00;
  localparam logic [3:0] CCU_MODE_ADC_TRIG = 4'hB;
  // Oscillator periods per bit period, minus one, indexed by clock select
  localparam logic [5:0] DIV_M1 [8] = '{6'h01, 6'h07, 6'h1F, 6'h00, 6'h03, 6'h0F, 6'h3F, 6'h00};
  // Pins that are analog inputs, indexed by port configuration
  localparam logic [7:0] ANALOG_MASK [16] = '{8'hFF, 8'hFF, 8'h1F, 8'h1F, 8'h0B, 8'h0B, 8'h00, 8'h00,
                                              8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h1F, 8'h0F, 8'h01, 8'h0D};
  typedef enum logic [1:0] {S_IDLE, S_CONV, S_WAIT, S_ACQ} adcs_state_t;
endpackage

/* shared/adcs_tick_if.sv */
// Bit-period tick link between sequencer and tick generator
`timescale 1ns/1ps
`default_nettype none
interface adcs_tick_if;
  logic ce;
  logic enable;
  logic [2:0] clk_sel;
  logic tick;
  modport gen (input ce, input enable, input clk_sel, output tick);
  modport user (output ce, output enable, output clk_sel, input tick);
endinterface
`default_nettype wire

/* hdl/adcs_tick_gen.sv */
// Conversion bit-period tick generator
`timescale 1ns/1ps
`default_nettype none
module adcs_tick_gen
  import adcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rc_clk_pin,
  adcs_tick_if.gen t
);
  logic [5:0] cnt_reg;
  logic rc_s1_reg;
  logic rc_s2_reg;
  logic rc_s3_reg;
  wire rc_mode = t.clk_sel[1] & t.clk_sel[0];
  wire [5:0] div_m1 = DIV_M1[t.clk_sel];
  wire rc_edge = rc_s2_reg & ~rc_s3_reg;
  wire div_hit = (cnt_reg == div_m1);

  // Tick only while enabled; divider restarts from zero each run
  assign t.tick = t.enable & (rc_mode ? rc_edge : div_hit);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 6'h00;
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_s3_reg <= 1'b0;
    end else if (t.ce) begin
      rc_s1_reg <= rc_clk_pin;
      rc_s2_reg <= rc_s1_reg;
      rc_s3_reg <= rc_s2_reg;
      if (!t.enable || div_hit) begin
        cnt_reg <= 6'h00;
      end else begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

  a_fast_divide: assert property (@(posedge clk) disable iff (rst)
    (t.ce && t.tick && t.clk_sel == 3'b000) |=> !t.tick)
    else $error("divide-by-two tick came back to back");
  a_slow_divide: assert property (@(posedge clk) disable iff (rst)
    (t.ce && t.tick && t.clk_sel == 3'b100) ##1 t.ce [*3] |-> !t.tick && !$past(t.tick) && !$past(t.tick, 2))
    else $error("divide-by-four tick too early");
endmodule
`default_nettype wire

/* hdl/adcs_sequencer.sv */
// Converter control and conversion sequencer with register port
`timescale 1ns/1ps
`default_nettype none
module adcs_sequencer
  import adcs_pkg::*;
#(
  parameter int PINS = CHAN_COUNT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [PINS-1:0] pin_level,
  input wire logic [PINS-1:0] pin_direction_bit,
  input wire logic [PINS-1:0] pin_out_level,
  input wire logic [ADC_BITS-1:0] analog_code,
  input wire logic rc_clk_pin,
  input wire logic [3:0] ccu_two_mode_field,
  input wire logic ccu_two_special_event,
  input wire logic ccu_two_timer_sel,
  output logic converter_power_on,
  output logic conv_busy,
  output logic acquiring,
  output logic conversion_done_flag,
  output logic timer_a_clear,
  output logic timer_b_clear
);
  adcs_tick_if tif ();

  adcs_state_t state_reg;
  adcs_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic on_reg;
  logic [2:0] clk_sel_reg;
  logic [2:0] chan_reg;
  logic just_reg;
  logic [3:0] pcfg_reg;
  logic [7:0] resh_reg;
  logic [7:0] resl_reg;
  logic done_reg;
  logic go_reg;
  logic acq_reg;
  logic restart_reg;
  logic [ADC_BITS-1:0] hold_reg;
  logic [7:0] rdata_reg;
  logic tmr_a_reg;
  logic tmr_b_reg;
  logic [PINS-1:0] pin_s1_reg;
  logic [PINS-1:0] pin_s2_reg;
  logic [ADC_BITS-1:0] ana_s1_reg;
  logic [ADC_BITS-1:0] ana_s2_reg;

  // Register decode
  wire wr0 = wr_en && addr == OFF_CTRL0;
  wire wr1 = wr_en && addr == OFF_CTRL1;
  wire wrh = wr_en && addr == OFF_RESH;
  wire wrl = wr_en && addr == OFF_RESL;
  wire wrs = wr_en && addr == OFF_STATUS;
  wire tick = tif.tick;
  wire in_conv = state_reg == S_CONV;

  // Special event in the ADC trigger mode: timer always cleared, conversion only when powered
  wire trig_mode = ccu_two_special_event && ccu_two_mode_field == CCU_MODE_ADC_TRIG;
  wire trig_hit = trig_mode && on_reg;
  // Go is honoured only when power was already on before this write
  wire sw_start = wr0 && wdata[GO_POS] && wdata[ON_POS] && on_reg;
  // Starts refused during the post-abort wait; the divider is mid-count there
  wire start_ok = state_reg == S_IDLE || state_reg == S_ACQ;
  wire start = (sw_start || trig_hit) && start_ok;
  // A trigger in the same cycle as a clearing write keeps go set
  wire sw_abort = wr0 && (!wdata[GO_POS] || !wdata[ON_POS]) && !trig_hit;
  wire abort = in_conv && sw_abort;
  wire finish = in_conv && tick && cnt_reg == 4'(CONV_TICKS - 1) && !abort;
  wire wait_done = state_reg == S_WAIT && tick && cnt_reg == 4'(ABORT_TICKS - 1);

  // Output pin converts its own drive level, else the analog sample
  wire [2:0] ch = chan_reg;
  wire [ADC_BITS-1:0] pin_word = {ADC_BITS{pin_out_level[ch]}};
  wire [ADC_BITS-1:0] sample = pin_direction_bit[ch] ? ana_s2_reg : pin_word;
  wire [7:0] res_h = just_reg ? {6'h00, hold_reg[9:8]} : hold_reg[9:2];
  wire [7:0] res_l = just_reg ? hold_reg[7:0] : {hold_reg[1:0], 6'h00};
  wire [7:0] port_view = pin_s2_reg & ~ANALOG_MASK[pcfg_reg];
  wire on_next = wr0 ? wdata[ON_POS] : on_reg;

  wire [7:0] ctrl0_view = {clk_sel_reg[1:0], chan_reg, go_reg, 1'b0, on_reg};
  wire [7:0] ctrl1_view = {just_reg, clk_sel_reg[2], 2'b00, pcfg_reg};
  wire [7:0] stat_view = {5'h00, go_reg, acq_reg, done_reg};
  wire [7:0] rd_mux = addr == OFF_CTRL0 ? ctrl0_view :
                      addr == OFF_CTRL1 ? ctrl1_view :
                      addr == OFF_RESH ? resh_reg :
                      addr == OFF_RESL ? resl_reg :
                      addr == OFF_STATUS ? stat_view :
                      addr == OFF_PORT ? port_view : 8'h00;

  // One idle cycle on abort restarts the divider on a clean boundary
  assign tif.ce = ce;
  assign tif.clk_sel = clk_sel_reg;
  assign tif.enable = (in_conv || state_reg == S_WAIT) && !restart_reg;

  adcs_tick_gen u_tick (
    .clk(clk),
    .rst(rst),
    .rc_clk_pin(rc_clk_pin),
    .t(tif)
  );

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      S_IDLE, S_ACQ: begin
        if (start) begin
          state_next = S_CONV;
          cnt_next = 4'h0;
        end else if (!on_next) begin
          state_next = S_IDLE;
        end
      end
      S_CONV: begin
        if (abort) begin
          state_next = S_WAIT;
          cnt_next = 4'h0;
        end else if (finish) begin
          state_next = S_IDLE;
        end else if (tick) begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      S_WAIT: begin
        if (!on_next) begin
          state_next = S_IDLE;
        end else if (wait_done) begin
          state_next = S_ACQ;
        end else if (tick) begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Synchronisers for pins and the sample-and-hold word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      ana_s1_reg <= '0;
      ana_s2_reg <= '0;
    end else if (ce) begin
      pin_s1_reg <= pin_level;
      pin_s2_reg <= pin_s1_reg;
      ana_s1_reg <= analog_code;
      ana_s2_reg <= ana_s1_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      go_reg <= 1'b0;
      acq_reg <= 1'b0;
      restart_reg <= 1'b0;
      hold_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      go_reg <= state_next == S_CONV;
      acq_reg <= state_next == S_ACQ;
      restart_reg <= abort;
      if (start) begin
        hold_reg <= sample;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on_reg <= CTRL0_RST[ON_POS];
      clk_sel_reg <= {CTRL1_RST[CS_HI_POS], CTRL0_RST[CS_LO_POS+1:CS_LO_POS]};
      chan_reg <= CTRL0_RST[CHAN_POS+2:CHAN_POS];
      just_reg <= CTRL1_RST[JUST_POS];
      pcfg_reg <= CTRL1_RST[PCFG_POS+3:PCFG_POS];
    end else if (ce) begin
      if (wr0) begin
        on_reg <= wdata[ON_POS];
        clk_sel_reg[1:0] <= wdata[CS_LO_POS+1:CS_LO_POS];
        chan_reg <= wdata[CHAN_POS+2:CHAN_POS];
      end
      if (wr1) begin
        clk_sel_reg[2] <= wdata[CS_HI_POS];
        just_reg <= wdata[JUST_POS];
        pcfg_reg <= wdata[PCFG_POS+3:PCFG_POS];
      end
    end
  end

  // Result bytes change only on completion or a direct write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resh_reg <= RES_RST;
      resl_reg <= RES_RST;
      done_reg <= 1'b0;
    end else if (ce) begin
      if (finish) begin
        resh_reg <= res_h;
        resl_reg <= res_l;
      end else begin
        if (wrh) begin
          resh_reg <= wdata;
        end
        if (wrl) begin
          resl_reg <= wdata;
        end
      end
      // Completion wins over a clearing write in the same cycle
      if (finish) begin
        done_reg <= 1'b1;
      end else if (wrs && !wdata[DONE_POS]) begin
        done_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      tmr_a_reg <= 1'b0;
      tmr_b_reg <= 1'b0;
    end else if (ce) begin
      rdata_reg <= rd_en ? rd_mux : 8'h00;
      tmr_a_reg <= trig_mode && !ccu_two_timer_sel;
      tmr_b_reg <= trig_mode && ccu_two_timer_sel;
    end
  end

  assign rdata = rdata_reg;
  assign converter_power_on = on_reg;
  assign conv_busy = go_reg;
  assign acquiring = acq_reg;
  assign conversion_done_flag = done_reg;
  assign timer_a_clear = tmr_a_reg;
  assign timer_b_clear = tmr_b_reg;

  a_conv_length: assert property (@(posedge clk) disable iff (rst)
    (ce && in_conv && tick && cnt_reg == 4'(CONV_TICKS - 2) && !sw_abort) |=> in_conv && cnt_reg == 4'hB)
    else $error("conversion did not reach its twelfth period");
  a_done_update: assert property (@(posedge clk) disable iff (rst)
    (ce && finish) |=> !go_reg && done_reg && !conv_busy && resl_reg == $past(res_l))
    else $error("completion did not update result and flags");
  a_abort_now: assert property (@(posedge clk) disable iff (rst)
    (ce && in_conv && sw_abort) |=> state_reg == S_WAIT && !go_reg && !done_reg == !$past(done_reg))
    else $error("cleared go did not abort");
  a_abort_keep: assert property (@(posedge clk) disable iff (rst)
    (ce && abort && !wrh && !wrl) |=> $stable(resh_reg) && $stable(resl_reg))
    else $error("abort changed result bytes");
  a_abort_wait: assert property (@(posedge clk) disable iff (rst)
    (ce && wait_done && on_next) |=> acquiring && state_reg == S_ACQ)
    else $error("acquisition did not start after wait");
  a_trigger_start: assert property (@(posedge clk) disable iff (rst)
    (ce && trig_hit && start_ok) |=> go_reg && cnt_reg == 4'h0)
    else $error("trigger did not start conversion");
  a_trigger_off: assert property (@(posedge clk) disable iff (rst)
    (ce && trig_mode && !on_reg && !sw_start && !in_conv) |=> !go_reg && (timer_a_clear || timer_b_clear))
    else $error("powered-off trigger misbehaved");
  a_port_mask: assert property (@(posedge clk) disable iff (rst)
    (ce && rd_en && addr == OFF_PORT) |=> (rdata & ANALOG_MASK[$past(pcfg_reg)]) == 8'h00)
    else $error("analog pin read nonzero");
  a_right_justify: assert property (@(posedge clk) disable iff (rst)
    (ce && finish && just_reg) |=> resh_reg[7:2] == 6'h00)
    else $error("right justified high byte not cleared");
  a_wait_refuse: assert property (@(posedge clk) disable iff (rst)
    (ce && state_reg == S_WAIT && !wait_done) |=> !go_reg)
    else $error("start taken during abort wait");
  a_timer_pulse: assert property (@(posedge clk) disable iff (rst)
    (ce && trig_mode) |=> timer_b_clear == $past(ccu_two_timer_sel) &&
      timer_a_clear == !$past(ccu_two_timer_sel))
    else $error("trigger did not clear the chosen timer");
endmodule
`default_nettype wire

/* bench/adcs_ccu_model.sv */
// Model of capture/compare unit two issuing special events
`timescale 1ns/1ps
`default_nettype none
module adcs_ccu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic timer_pick,
  input wire logic [3:0] mode_req,
  output logic [3:0] ccu_two_mode_field,
  output logic ccu_two_special_event,
  output logic ccu_two_timer_sel
);
  // Mode and timer choice settle before the one-cycle event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ccu_two_mode_field <= 4'h0;
      ccu_two_special_event <= 1'b0;
      ccu_two_timer_sel <= 1'b0;
    end else begin
      ccu_two_mode_field <= mode_req;
      ccu_two_timer_sel <= timer_pick;
      ccu_two_special_event <= fire;
    end
  end
endmodule
`default_nettype wire

/* bench/tb_adc_conversion_sequencer.sv */
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_sequencer;
  import adcs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rc_clk_pin = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, pin_level = 8'h00, pin_dir = 8'hFF, pin_out = 8'h00;
  logic [9:0] analog_code = 10'h000;
  logic fire = 1'b0, timer_pick = 1'b0;
  logic [3:0] mode_req = 4'h0, mode;
  logic ev, tsel, power, busy, acq, done, ta_clr, tb_clr;
  int mismatches = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;
  always #37 rc_clk_pin = ~rc_clk_pin;

  adcs_ccu_model u_ccu (.clk(clk), .rst(rst), .fire(fire), .timer_pick(timer_pick), .mode_req(mode_req),
    .ccu_two_mode_field(mode), .ccu_two_special_event(ev), .ccu_two_timer_sel(tsel));

  adcs_sequencer u_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .pin_level(pin_level), .pin_direction_bit(pin_dir),
    .pin_out_level(pin_out), .analog_code(analog_code), .rc_clk_pin(rc_clk_pin),
    .ccu_two_mode_field(mode), .ccu_two_special_event(ev), .ccu_two_timer_sel(tsel),
    .converter_power_on(power), .conv_busy(busy), .acquiring(acq), .conversion_done_flag(done),
    .timer_a_clear(ta_clr), .timer_b_clear(tb_clr));

  task conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  // Counts cycles with busy high; bounded so a stuck conversion ends the wait
  task busy_len(output int n);
    int k;
    n = 0;
    for (k = 0; k < 2000; k++) begin
      #1;
      if (busy === 1'b1)
        n++;
      else if (n > 0)
        break;
      @(posedge clk);
    end
  endtask

  task trig(input logic [3:0] m, input logic pick, output logic [1:0] clr);
    @(posedge clk);
    mode_req <= m;
    timer_pick <= pick;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    clr = 2'b00;
    repeat (4) begin
      @(posedge clk);
      #1 clr = clr | {tb_clr, ta_clr};
    end
  endtask

  function automatic int div_of(input logic [2:0] cs);
    case (cs)
      3'h0: return 2;
      3'h4: return 4;
      3'h1: return 8;
      3'h5: return 16;
      3'h2: return 32;
      default: return 64;
    endcase
  endfunction

  initial begin
    #300000;
    mismatches++;
    conclude();
  end

  initial begin
    logic [7:0] r, h;
    logic [2:0] cs, ch;
    logic [3:0] pc;
    logic [1:0] c;
    logic [9:0] d;
    logic j;
    int n, i;
    logic [2:0] codes [6];
    codes = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    void'($urandom(66));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      rd(3'(i), r);
      check("reset register", 16'(r), 16'h0000);
    end
    // Power first, go in a later write; short bit periods only cost accuracy
    wr(OFF_CTRL0, 8'h01);
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      cs = codes[i];
      ch = 3'($urandom);
      pc = 4'($urandom);
      j = 1'($urandom);
      d = 10'($urandom);
      pin_dir <= 8'($urandom);
      pin_out <= 8'($urandom);
      analog_code <= d;
      wr(OFF_CTRL1, {j, cs[2], 2'b00, pc});
      wr(OFF_CTRL0, {cs[1:0], ch, 3'b001});
      wr(OFF_CTRL0, {cs[1:0], ch, 3'b101});
      busy_len(n);
      check("busy cycles", 16'(n), 16'(12 * div_of(cs)));
      if (pin_dir[ch] == 1'b0)
        d = {10{pin_out[ch]}};
      rd(OFF_RESH, h);
      rd(OFF_RESL, r);
      check("result", {h, r}, j ? {6'h00, d} : {d, 6'h00});
      rd(OFF_CTRL0, r);
      check("go after done", 16'(r[GO_POS]), 16'h0000);
      check("done flag", 16'(done), 16'h0001);
      wr(OFF_STATUS, 8'h00);
      #1 check("done cleared", 16'(done), 16'h0000);
    end
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      pc = 4'($urandom);
      pin_level <= 8'($urandom);
      wr(OFF_CTRL1, {4'h0, pc});
      repeat (3) @(posedge clk);
      rd(OFF_PORT, r);
      check("port read", 16'(r), 16'(pin_level & ~ANALOG_MASK[pc]));
    end
    wr(OFF_RESH, 8'hA5);
    wr(OFF_RESL, 8'h5A);
    wr(OFF_CTRL1, 8'h80);
    wr(OFF_CTRL0, 8'h05);
    repeat (6) @(posedge clk);
    wr(OFF_CTRL0, 8'h01);
    @(posedge clk);
    #1 check("abort busy", 16'(busy), 16'h0000);
    for (n = 0; n < 20 && acq !== 1'b1; n++)
      @(posedge clk) #1;
    check("abort wait", 16'(n), 16'(ABORT_TICKS * 2));
    check("acquiring", 16'(acq), 16'h0001);
    rd(OFF_RESH, h);
    rd(OFF_RESL, r);
    check("result kept", {h, r}, 16'hA55A);
    check("no done on abort", 16'(done), 16'h0000);
    wr(OFF_CTRL0, 8'h00);
    trig(CCU_MODE_ADC_TRIG, 1'b1, c);
    check("timer b clear", 16'(c), 16'h0002);
    check("ignored trigger", 16'(busy), 16'h0000);
    // Channel is chosen and settled before any trigger
    wr(OFF_CTRL0, 8'h01);
    trig(4'h3, 1'b0, c);
    check("other mode", 16'(busy), 16'h0000);
    trig(CCU_MODE_ADC_TRIG, 1'b0, c);
    check("timer a clear", 16'(c), 16'h0001);
    check("trigger start", 16'(busy), 16'h0001);
    busy_len(n);
    check("trigger done", 16'(done), 16'h0001);
    // Clock enable low freezes the count; ten frozen edges lengthen busy by ten
    wr(OFF_CTRL0, 8'h05);
    repeat (3) @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    busy_len(n);
    check("frozen length", 16'(n + 13), 16'(CONV_TICKS * 2 + 10));
    // RC source runs free at 74 ns; twelve of its periods land within 80 to 96 cycles
    wr(OFF_CTRL0, 8'hC1);
    wr(OFF_CTRL0, 8'hC5);
    busy_len(n);
    check("rc length", 16'(n >= 80 && n <= 96), 16'h0001);
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_CTRL0, 8'h05);
    @(posedge clk);
    #1 check("go with power", 16'(busy), 16'h0000);
    wr(OFF_CTRL0, 8'h01);
    wr(OFF_CTRL0, 8'h05);
    repeat (4) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1 check("reset outputs", 16'({power, busy, done}), 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    rd(OFF_CTRL0, r);
    rd(OFF_RESH, h);
    check("reset regs", {h, r}, 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
